// ### logic/clkmon_pkg.sv
package clkmon_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DCO  = 4'h4;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int BIT_IRQ_EN  = 7;
  localparam int BIT_FAULT   = 6;
  localparam int BIT_MON_EN  = 5;
  localparam int BIT_SRC     = 4;
  localparam int BIT_INT_ON  = 3;
  localparam int BIT_INT_STB = 2;
  localparam int BIT_EXT_ON  = 1;
  localparam int BIT_EXT_STB = 0;

  // ----------------------------------------------------------------
  // dco readback fields
  // ----------------------------------------------------------------
  localparam int DCO_STG_LSB = 0;
  localparam int DCO_DIV_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       RST_INT_ON = 1'b1;
  localparam logic       RST_EXT_ON = 1'b0;
  localparam logic [7:0] RST_STAGE  = 8'h00;
  localparam logic [3:0] RST_DIV    = 4'h0;

  // ----------------------------------------------------------------
  // oscillator arithmetic
  // ----------------------------------------------------------------
  localparam logic [4:0] RING_BASE   = 5'h11;
  localparam logic [3:0] DIV_MAX     = 4'h9;
  localparam logic [8:0] STEP_FINE   = 9'h001;
  localparam logic [8:0] STEP_COARSE = 9'h020;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### logic/clock_monitor_dco_ctrl.sv
`timescale 1ns/100ps

// How it works
// [R1] monitor enable sets only if both oscillators are on and stable at the write.
// [R2] monitor irq enable sets only while monitor enable is already set.
// [R3] fault flag bit 6 clears by reading control then writing zero; one keeps it.
// [R4] monitor enable stays set when a stable bit later drops.
// [R5] on detected loss both clock selects move to the surviving oscillator.
// [R6] the fault handler must clear monitor enable after a clock loss.
// [R7] software enables clocks, waits stable, switches, enables monitor, then irq.
// [R8] software must set the slow crystal option to match the external clock.
// [R9] control bits: 7 irq en, 5 mon en, 4 source, 3..0 on/stable pairs.
// [R10] oscillator period set only by stage and divider codes, in discrete steps.
// [R11] divider is two to the divider code, saturating at nine, divide by 512.
// [R12] divider code changes only by carry or borrow of stage arithmetic.
// [R13] ring length is 17 plus twice the top three stage bits.
// [R14] large error steps stage bit 5, small error steps stage bit 0.
// [R15] low five stage bits set how many of 32 cycles run two stages longer.
// [R16] apart from the [R5] forced switch, source select changes only if the target oscillator is on and stable.
// [R17] irq request is high while fault flag and irq enable are both set.
// [R18] fault flag sets when monitor is on and an inactivity indication rises.
module clock_monitor_dco_ctrl
  import clkmon_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  logic              clk,
  input  logic              sys_rst,
  // axi4-lite slave
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  // oscillator status pins
  input  logic              int_stable_in,
  input  logic              ext_stable_in,
  input  logic              int_inactive_in,
  input  logic              ext_inactive_in,
  // loop filter requests
  input  logic              lf_up_in,
  input  logic              lf_down_in,
  input  logic              lf_coarse_in,
  // clock control outputs
  output logic              internal_osc_on,
  output logic              external_osc_on,
  output logic              osc_output_clock_sel,
  output logic              timebase_clock_sel,
  output logic              monitor_irq,
  // digital oscillator outputs
  output logic [7:0]        stage_control,
  output logic [3:0]        divider_control,
  output logic [4:0]        ring_length,
  output logic              ring_long,
  output logic [9:0]        divide_ratio
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] eff_div(input logic [3:0] d);
    eff_div = (d > DIV_MAX) ? DIV_MAX : d;
  endfunction

  function automatic logic [4:0] ring_stages(input logic [2:0] hi);
    ring_stages = RING_BASE + {1'b0, hi, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0] sync1_r, sync2_r;
  logic       int_off_d_r, ext_off_d_r, up_d_r, dn_d_r;
  logic       irq_en_r, fault_r, mon_en_r, src_r, int_on_r, ext_on_r;
  logic       clr_arm_r, tb_sel_r, irq_r;
  logic [7:0] stage_r;
  logic [3:0] div_r;
  logic [4:0] ring_len_r, acc_r;
  logic       ring_long_r;
  logic [9:0] div_ratio_r;
  logic       bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {lf_coarse_in, lf_down_in, lf_up_in, ext_inactive_in,
                  int_inactive_in, ext_stable_in, int_stable_in};
      sync2_r <= sync1_r;
    end
  end

  // a stable report from a switched-off oscillator is stale, so mask it
  wire int_stb  = sync2_r[0] & int_on_r;
  wire ext_stb  = sync2_r[1] & ext_on_r;
  wire int_off  = sync2_r[2];
  wire ext_off  = sync2_r[3];
  wire lf_up    = sync2_r[4];
  wire lf_dn    = sync2_r[5];
  wire lf_crs   = sync2_r[6];
  wire int_rise = int_off & ~int_off_d_r;
  wire ext_rise = ext_off & ~ext_off_d_r;
  wire up_rise  = lf_up & ~up_d_r;
  wire dn_rise  = lf_dn & ~dn_d_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  wire       wr_hit  = (s_axi_awaddr == ADDR_CTRL) || (s_axi_awaddr == ADDR_DCO);
  wire       wr_ctrl = wr_fire & (s_axi_awaddr == ADDR_CTRL) & s_axi_wstrb[0];
  wire       rd_fire = s_axi_arvalid & ~rvalid_r;
  wire       rd_ctrl = rd_fire & (s_axi_araddr == ADDR_CTRL);
  wire       rd_dco  = rd_fire & (s_axi_araddr == ADDR_DCO);
  wire [7:0] wd      = s_axi_wdata[7:0];

  // ----------------------------------------------------------------
  // control register next values
  // ----------------------------------------------------------------
  wire mon_prereq = int_on_r & ext_on_r & int_stb & ext_stb;
  wire int_ok     = int_on_r & int_stb;
  wire ext_ok     = ext_on_r & ext_stb;
  wire forced_ext = mon_en_r & int_off;
  wire forced_int = mon_en_r & ext_off & ~int_off;
  wire forced     = forced_ext | forced_int;
  wire src_req_ok = wd[BIT_SRC] ? ext_ok : int_ok;
  wire fault_set  = mon_en_r & (int_rise | ext_rise);
  wire fault_clr  = wr_ctrl & ~wd[BIT_FAULT] & clr_arm_r;

  // stability is looked at only on the setting write; later drops are ignored
  wire mon_en_nxt = wr_ctrl ? (wd[BIT_MON_EN] & (mon_en_r | mon_prereq))  // [R1] [R4]
                            : mon_en_r;
  wire irq_en_nxt = wr_ctrl ? (wd[BIT_IRQ_EN] & mon_en_r) : irq_en_r;     // [R2]
  // a new loss event wins over a clear in the same cycle
  wire fault_nxt  = fault_set | (fault_r & ~fault_clr);                   // [R3] [R18]
  wire clr_arm_nxt = (rd_ctrl & fault_r) ? 1'b1 : (fault_clr ? 1'b0 : clr_arm_r);
  wire src_nxt    = forced_ext ? 1'b1 :                                   // [R5]
                    forced_int ? 1'b0 :
                    (wr_ctrl & src_req_ok) ? wd[BIT_SRC] : src_r;          // [R16]
  // the selected oscillator cannot be switched off underneath the system
  wire int_on_nxt = wr_ctrl ? (wd[BIT_INT_ON] | ~src_nxt) : int_on_r;
  wire ext_on_nxt = wr_ctrl ? (wd[BIT_EXT_ON] | src_nxt) : ext_on_r;
  wire tb_sel_nxt = forced_ext ? 1'b1 : (forced_int ? 1'b0 : ext_on_r);   // [R5]

  wire [7:0] ctrl_view = {irq_en_r, fault_r, mon_en_r, src_r,             // [R9]
                          int_on_r, int_stb, ext_on_r, ext_stb};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_r    <= 1'b0;
      fault_r     <= 1'b0;
      mon_en_r    <= 1'b0;
      src_r       <= 1'b0;
      int_on_r    <= RST_INT_ON;
      ext_on_r    <= RST_EXT_ON;
      clr_arm_r   <= 1'b0;
      tb_sel_r    <= 1'b0;
      irq_r       <= 1'b0;
      int_off_d_r <= 1'b0;
      ext_off_d_r <= 1'b0;
    end else begin
      irq_en_r    <= irq_en_nxt;
      fault_r     <= fault_nxt;
      mon_en_r    <= mon_en_nxt;
      src_r       <= src_nxt;
      int_on_r    <= int_on_nxt;
      ext_on_r    <= ext_on_nxt;
      clr_arm_r   <= clr_arm_nxt;
      tb_sel_r    <= tb_sel_nxt;
      irq_r       <= fault_nxt & irq_en_nxt;                                // [R17]
      int_off_d_r <= int_off;
      ext_off_d_r <= ext_off;
    end
  end

  // ----------------------------------------------------------------
  // loop filter arithmetic
  // ----------------------------------------------------------------
  wire [8:0] step   = lf_crs ? STEP_COARSE : STEP_FINE;                   // [R14]
  wire [8:0] sum_up = {1'b0, stage_r} + step;
  wire [8:0] sum_dn = {1'b0, stage_r} - step;
  wire       carry  = sum_up[8];
  wire       borrow = sum_dn[8];
  wire       go_up  = up_rise & ~dn_rise;
  wire       go_dn  = dn_rise & ~up_rise;

  // divider moves only on carry or borrow; at either end the stage clamps
  wire [7:0] stage_nxt = go_up ? ((carry & (div_r >= DIV_MAX)) ? 8'hFF : sum_up[7:0]) :
                         go_dn ? ((borrow & (div_r == 4'h0)) ? 8'h00 : sum_dn[7:0]) :
                         stage_r;
  wire [3:0] div_nxt   = (go_up & carry & (div_r < DIV_MAX)) ? div_r + 4'h1 :    // [R12]
                         (go_dn & borrow & (div_r != 4'h0)) ? div_r - 4'h1 :
                         div_r;

  // fine adjust: accumulator carries exactly stage[4:0] times per 32 cycles;
  // the clk stands in for ring cycles, and the top code's divide-by-two is
  // left to the analog ring
  wire [5:0] acc_sum = {1'b0, acc_r} + {1'b0, stage_r[4:0]};              // [R15]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_r     <= RST_STAGE;
      div_r       <= RST_DIV;
      up_d_r      <= 1'b0;
      dn_d_r      <= 1'b0;
      acc_r       <= 5'h00;
      ring_long_r <= 1'b0;
      ring_len_r  <= RING_BASE;
      div_ratio_r <= 10'h001;
    end else begin
      stage_r     <= stage_nxt;                                            // [R10]
      div_r       <= div_nxt;
      up_d_r      <= lf_up;
      dn_d_r      <= lf_dn;
      acc_r       <= acc_sum[4:0];
      ring_long_r <= acc_sum[5];                                           // [R15]
      ring_len_r  <= ring_stages(stage_r[7:5]);                            // [R13]
      div_ratio_r <= 10'h001 << eff_div(div_r);                            // [R11]
    end
  end

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rresp_r  <= (rd_ctrl | rd_dco) ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_ctrl ? {24'h000000, ctrl_view} :
                    rd_dco  ? {20'h00000, eff_div(div_r), stage_r} : 32'h0000_0000;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready        = wr_fire;
  assign s_axi_wready         = wr_fire;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = ~rvalid_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rresp          = rresp_r;
  assign s_axi_rdata          = rdata_r;
  assign internal_osc_on      = int_on_r;
  assign external_osc_on      = ext_on_r;
  assign osc_output_clock_sel = src_r;
  assign timebase_clock_sel   = tb_sel_r;
  assign monitor_irq          = irq_r;
  assign stage_control        = stage_r;
  assign divider_control      = div_r;
  assign ring_length          = ring_len_r;
  assign ring_long            = ring_long_r;
  assign divide_ratio         = div_ratio_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_MON_GATE: assert property ( // [R1]
    $rose(mon_en_r) |-> $past(wr_ctrl) && $past(mon_prereq))
    else $error("monitor enable set without prerequisites");

  AST_IRQEN_GATE: assert property ( // [R2]
    $rose(irq_en_r) |-> $past(mon_en_r))
    else $error("irq enable set while monitor off");

  AST_FAULT_CLR: assert property ( // [R3]
    $fell(fault_r) |-> $past(wr_ctrl) && !$past(wd[BIT_FAULT]) && $past(clr_arm_r))
    else $error("fault flag cleared without read then zero write");

  AST_FAULT_W1: assert property ( // [R3]
    fault_r && wr_ctrl && wd[BIT_FAULT] |=> fault_r)
    else $error("writing one disturbed fault flag");

  AST_MON_HOLD: assert property ( // [R4]
    mon_en_r && !wr_ctrl |=> mon_en_r)
    else $error("monitor enable dropped without a write");

  AST_FORCE_EXT: assert property ( // [R5]
    mon_en_r && int_off |=> src_r && timebase_clock_sel)
    else $error("no switch to external after internal loss");

  AST_FORCE_INT: assert property ( // [R5]
    mon_en_r && ext_off && !int_off |=> !src_r && !timebase_clock_sel)
    else $error("no switch to internal after external loss");

  AST_CTRL_MAP: assert property ( // [R9]
    rd_ctrl |=> s_axi_rvalid && s_axi_rdata[5] == $past(mon_en_r)
                && s_axi_rdata[6] == $past(fault_r) && s_axi_rdata[7] == $past(irq_en_r))
    else $error("control readback layout wrong");

  AST_DIV_SAT: assert property ( // [R11]
    div_r <= DIV_MAX ##1 $onehot(divide_ratio) && divide_ratio <= 10'h200)
    else $error("divider out of range");

  AST_DIV_STEP: assert property ( // [R12]
    $changed(div_r) |-> ($past(go_up) && $past(carry)) || ($past(go_dn) && $past(borrow)))
    else $error("divider moved without carry or borrow");

  AST_RING: assert property ( // [R13]
    1'b1 |=> ring_length == RING_BASE + 2 * $past(stage_r[7:5]))
    else $error("ring length mismatch");

  AST_COARSE: assert property ( // [R14]
    go_up && lf_crs && !carry |=> stage_r == $past(stage_r) + 8'h20)
    else $error("coarse step not bit 5");

  AST_FINE: assert property ( // [R14]
    go_dn && !lf_crs && !borrow |=> stage_r == $past(stage_r) - 8'h01)
    else $error("fine step not bit 0");

  AST_DITHER: assert property ( // [R15]
    stage_r[4:0] == 5'h00 [*2] |-> !ring_long)
    else $error("long cycle with zero fine code");

  AST_SRC_GATE: assert property ( // [R16]
    $changed(src_r) && !$past(forced) |-> (src_r ? $past(ext_ok) : $past(int_ok)))
    else $error("source switched to unready oscillator");

  AST_IRQ: assert property ( // [R17]
    monitor_irq == (fault_r && irq_en_r))
    else $error("irq does not follow flag and enable");

  AST_FAULT_SET: assert property ( // [R18]
    mon_en_r && (int_rise || ext_rise) |=> fault_r)
    else $error("loss did not set fault flag");

  COV_FORCE: cover property (mon_en_r && int_rise ##1 src_r);
  COV_CLEAR: cover property (rd_ctrl && fault_r ##[1:20] $fell(fault_r));
  COV_IRQ: cover property ($rose(monitor_irq));
  COV_CARRY: cover property ($changed(div_r));

endmodule // clock_monitor_dco_ctrl

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import clkmon_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        int_stb = 1'b1, ext_stb = 1'b1, int_off = 1'b0, ext_off = 1'b0;
  logic        lf_up = 1'b0, lf_dn = 1'b0, lf_coarse = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, int_on, ext_on, out_sel, tb_sel, irq;
  logic        ring_long;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  stage;
  logic [3:0]  divider;
  logic [4:0]  ring_len;
  logic [9:0]  ratio;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #50 clk = ~clk;
  clock_monitor_dco_ctrl clock_monitor_dco_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .int_stable_in(int_stb), .ext_stable_in(ext_stb),
    .int_inactive_in(int_off), .ext_inactive_in(ext_off),
    .lf_up_in(lf_up), .lf_down_in(lf_dn), .lf_coarse_in(lf_coarse),
    .internal_osc_on(int_on), .external_osc_on(ext_on),
    .osc_output_clock_sel(out_sel), .timebase_clock_sel(tb_sel), .monitor_irq(irq),
    .stage_control(stage), .divider_control(divider), .ring_length(ring_len),
    .ring_long(ring_long), .divide_ratio(ratio)
  );
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ready and answers are read at the rising edge, before that edge's updates land;
  // no wait is capped here, only the watchdog ends a hang
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk("read data", e, d);
    chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  // write control, let the status pins settle through the synchroniser, read back
  task automatic wrc(input logic [7:0] d, input logic [7:0] e);
    logic [1:0] r;
    axi_wr(ADDR_CTRL, {24'h0, d}, r);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    cyc(6);
    rd_chk(ADDR_CTRL, {24'h0, e});
  endtask
  task automatic step(input logic up, input int n);
    repeat (n) begin
      if (up) lf_up <= 1'b1; else lf_dn <= 1'b1;
      cyc(4);
      lf_up <= 1'b0; lf_dn <= 1'b0;
      cyc(4);
    end
  endtask
  task automatic count_long(input int e);
    int c;
    c = 0;
    repeat (32) begin @(posedge clk); if (ring_long === 1'b1) c++; end
    chk("ring_long count", e, c);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("ring_length", 32'h11, ring_len);
    chk("divide_ratio", 32'h1, ratio);
    rd_chk(ADDR_CTRL, 32'h0C);
    wrc(8'h20, 8'h0C);
  endtask
  task automatic t_enable;
    wrc(8'hBF, 8'h0F);
    wrc(8'hBF, 8'h3F);
    wrc(8'hBF, 8'hBF);
    chk("out sel", 1, out_sel);
    ext_stb <= 1'b0;
    cyc(6);
    rd_chk(ADDR_CTRL, 32'hBE);
  endtask
  task automatic t_fault;
    ext_off <= 1'b1;
    cyc(6);
    chk("out sel forced", 0, out_sel);
    chk("tb sel forced", 0, tb_sel);
    chk("irq", 1, irq);
    rd_chk(ADDR_CTRL, 32'hEE);
    ext_off <= 1'b0; ext_stb <= 1'b1;
    cyc(6);
    wrc(8'hEF, 8'hEF);
    chk("irq kept", 1, irq);
    wrc(8'hAF, 8'hAF);
    chk("irq cleared", 0, irq);
    wrc(8'h0F, 8'h0F);
  endtask
  task automatic t_switch;
    wrc(8'h13, 8'h13);
    chk("tb sel", 1, tb_sel);
    chk("int on pin", 0, int_on);
    chk("ext on pin", 1, ext_on);
    wrc(8'h03, 8'h13);
    wrc(8'h1F, 8'h1F);
    wrc(8'h0F, 8'h0F);
    chk("out sel back", 0, out_sel);
  endtask
  // internal loss with the monitor on and its interrupt off
  task automatic t_int_loss;
    wrc(8'h2F, 8'h2F);
    int_off <= 1'b1;
    cyc(6);
    chk("out sel ext", 1, out_sel);
    chk("tb sel ext", 1, tb_sel);
    chk("irq masked", 0, irq);
    rd_chk(ADDR_CTRL, 32'h7F);
    int_off <= 1'b0;
    cyc(6);
    wrc(8'h0F, 8'h0F);
  endtask
  task automatic t_dco;
    step(1'b1, 3);
    chk("stage fine", 32'h03, stage);
    count_long(3);
    lf_coarse <= 1'b1;
    cyc(6);
    step(1'b1, 8);
    rd_chk(ADDR_DCO, 32'h103);
    chk("ratio div1", 32'h2, ratio);
    step(1'b0, 1);
    rd_chk(ADDR_DCO, 32'h0E3);
    chk("ring_length top", 32'h1F, ring_len);
    chk("ratio div0", 32'h1, ratio);
    step(1'b1, 73);
    rd_chk(ADDR_DCO, 32'h9FF);
    chk("ratio max", 32'h200, ratio);
    chk("divider max", 32'h9, divider);
    count_long(31);
  endtask
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(4'h8, 32'hFF, r);
    chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(4'h8, d, r);
    chk("unmapped rd", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    axi_wr(ADDR_DCO, 32'h0, r);
    chk("dco wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd_chk(ADDR_DCO, 32'h9FF);
  endtask
  // ----------------------------------------------------------------
  // verdict and run control
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(12);
    sys_rst <= 1'b0;
    cyc(6);
    t_reset();
    t_enable();
    t_fault();
    t_switch();
    t_int_loss();
    t_dco();
    t_unmapped();
    print_verdict();
  end
  // the whole sequence needs about a thousand cycles; this leaves ample margin
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end
endmodule // testbench
